/* File: design/arc_pkg.sv */
// shared constants and types of the automatic restart controller
package arc_pkg;
    // register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int TIME_W = 16;
    localparam int CNT_W = 8;
    // register byte offsets, one aligned word each
    localparam logic [7:0] OFF_MODE = 8'h00;
    localparam logic [7:0] OFF_ATTEMPTS = 8'h04;
    localparam logic [7:0] OFF_DELAY = 8'h08;
    localparam logic [7:0] OFF_MONITOR = 8'h0c;
    localparam logic [7:0] OFF_CTRL = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    // control register bit positions
    localparam int CTRL_INFEED_BIT = 0;
    localparam int CTRL_CLR_EXC_BIT = 1;
    // restart mode encodings
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_ACK = 3'h1;
    localparam logic [2:0] MODE_LINE = 3'h4;
    localparam logic [2:0] MODE_ANY = 3'h6;
    // values after reset
    localparam logic [2:0] RST_MODE = 3'h0;
    localparam logic [CNT_W-1:0] RST_ATTEMPTS = 8'h03;
    localparam logic [TIME_W-1:0] RST_DELAY_MS = 16'h03e8;
    localparam logic [TIME_W-1:0] RST_MONITOR_MS = 16'hea60;
    // timing: one timer tick per millisecond at a 125 MHz clock
    localparam int CLK_PERIOD_NS = 8;
    localparam int TICK_TIME_NS = 1000000;
    localparam int TICK_CYCLES = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SUCCESS_HOLD_S = 1;
    localparam logic [TIME_W-1:0] SUCCESS_HOLD_MS = TIME_W'(SUCCESS_HOLD_S * 1000);
    // restart sequencer states
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ACK = 5'b00010,
        ST_WAIT = 5'b00100,
        ST_START = 5'b01000,
        ST_LOCK = 5'b10000
    } arc_state_e;
endpackage

/* File: design/arc_sync2.sv */
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/10ps
`default_nettype none
module arc_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1;

    // first stage is read only by the second stage
    always_ff @(posedge clk) begin
        if (!nrst) begin
            stage1 <= '0;
            dout <= '0;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule
`default_nettype wire

/* File: design/arc_ms_tick.sv */
// divider giving a one-cycle tick per timer period
`timescale 1ns/10ps
`default_nettype none
module arc_ms_tick #(
    parameter int TICK_CYCLES = 125000
) (
    input wire logic clk,
    input wire logic nrst,
    output logic tick
);
    localparam int CW = $clog2(TICK_CYCLES + 1);
    logic [CW-1:0] divCnt;
    logic [CW-1:0] next_divCnt;
    logic next_tick;

    if (TICK_CYCLES < 2) begin : g_chk
        $error("arc_ms_tick: TICK_CYCLES must be at least 2");
    end

    // count down and pulse on wrap
    always_comb begin
        next_tick = 1'b0;
        next_divCnt = divCnt - CW'(1);
        if (divCnt == '0) begin
            next_divCnt = CW'(TICK_CYCLES - 1);
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            divCnt <= '0;
            tick <= 1'b0;
        end else begin
            divCnt <= next_divCnt;
            tick <= next_tick;
        end
    end
endmodule
`default_nettype wire

/* File: design/arc_restart_ctrl.sv */
// automatic restart controller: fault acknowledge and drive power-up sequencer
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// RULE1: mode 0 off, 1 ack, 4 line, 6 any
// RULE2: on supply return acknowledge faults, power up
// RULE3: ack-only mode acknowledges faults, never restarts
// RULE4: later faults in ack-only mode also acknowledged
// RULE5: run high: delay plus 1s between faults
// RULE6: run low: 1s between ack and fault
// RULE7: ack-only mode never raises attempts-exceeded fault
// RULE8: line mode restarts only on line events
// RULE9: line mode acknowledges other faults, continues attempt
// RULE10: aux supply loss counts as line failure
// RULE11: any-fault mode restarts on fault or trigger0
// RULE12: any-fault attempts come from attempt count setting
// RULE13: any-fault mode watches restart with monitor time
// RULE14: mode above one may start drive automatically
// RULE15: other side should enable flying restart
// RULE16: x setting gives x+1 attempts, then fault
// RULE17: decrement per ack, ack every half delay
// RULE18: success after magnetization plus 1s, reload counter
// RULE19: monitor expiry raises fault, zero disables
// RULE20: reset clears counter, timers, sequencer idle
module arc_restart_ctrl
    import arc_pkg::*;
#(
    parameter int TICK_CYCLES = arc_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [arc_pkg::ADDR_W-1:0] regAddr,
    input wire logic [arc_pkg::DATA_W-1:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [arc_pkg::DATA_W-1:0] regRdData,
    input wire logic faultPending,
    input wire logic moduleLineFailureFault,
    input wire logic infeedLineFailureFault,
    input wire logic auxSupplyLost,
    input wire logic [1:0] restartTriggerInputs,
    input wire logic runCommand,
    input wire logic infeedReady,
    input wire logic magnetizationDoneFlag,
    output logic faultAck,
    output logic powerUpReq,
    output logic attemptsExceededFault,
    output logic restartActive
);
    import arc_pkg::*;

    localparam int SYNC_W = 9;

    logic tick;
    logic [SYNC_W-1:0] pinSync;
    logic fault, modLine, infLine, auxLost, trig0, trig1, runCmd, ready, magDone;

    // configuration registers
    logic [2:0] restartModeSelect, next_restartModeSelect;
    logic [CNT_W-1:0] startAttemptCount, next_startAttemptCount;
    logic [TIME_W-1:0] attemptDelayTime, next_attemptDelayTime;
    logic [TIME_W-1:0] supplyReturnMonitorTime, next_supplyReturnMonitorTime;
    logic infeedObject, next_infeedObject;
    logic [DATA_W-1:0] next_regRdData;
    logic clrExc;

    // sequencer state
    arc_state_e state, next_state;
    logic [CNT_W-1:0] attemptCnt, next_attemptCnt;
    logic [TIME_W-1:0] phaseMs, next_phaseMs;
    logic [TIME_W-1:0] monitorMs, next_monitorMs;
    logic ackIssued, next_ackIssued;
    logic next_faultAck, next_powerUpReq, next_exc, next_restartActive;

    // decoded conditions
    logic modeRestart, lineEvt, qualify, succAck, monExpire, successEvt, excSet;
    logic [TIME_W-1:0] halfDelay;

    arc_ms_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk(clk),
        .nrst(nrst),
        .tick(tick)
    );

    // every pin level crosses two flops before any logic sees it
    arc_sync2 #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clk(clk),
        .nrst(nrst),
        .din({faultPending, moduleLineFailureFault, infeedLineFailureFault, auxSupplyLost,
              restartTriggerInputs, runCommand, infeedReady, magnetizationDoneFlag}),
        .dout(pinSync)
    );

    assign {fault, modLine, infLine, auxLost, trig1, trig0, runCmd, ready, magDone} = pinSync;

    // register writes; software owns only the configuration
    always_comb begin
        next_restartModeSelect = restartModeSelect;
        next_startAttemptCount = startAttemptCount;
        next_attemptDelayTime = attemptDelayTime;
        next_supplyReturnMonitorTime = supplyReturnMonitorTime;
        next_infeedObject = infeedObject;
        clrExc = 1'b0;
        if (regWrite) begin
            unique case (regAddr)
                OFF_MODE: next_restartModeSelect = regWrData[2:0];
                OFF_ATTEMPTS: next_startAttemptCount = regWrData[CNT_W-1:0];
                OFF_DELAY: next_attemptDelayTime = regWrData[TIME_W-1:0];
                OFF_MONITOR: next_supplyReturnMonitorTime = regWrData[TIME_W-1:0];
                OFF_CTRL: begin
                    next_infeedObject = regWrData[CTRL_INFEED_BIT];
                    clrExc = regWrData[CTRL_CLR_EXC_BIT];
                end
                default: ;
            endcase
        end
    end

    // read data stands only in the cycle after the strobe; unmapped reads zero
    always_comb begin
        next_regRdData = '0;
        if (regRead) begin
            unique case (regAddr)
                OFF_MODE: next_regRdData[2:0] = restartModeSelect;
                OFF_ATTEMPTS: next_regRdData[CNT_W-1:0] = startAttemptCount;
                OFF_DELAY: next_regRdData[TIME_W-1:0] = attemptDelayTime;
                OFF_MONITOR: next_regRdData[TIME_W-1:0] = supplyReturnMonitorTime;
                OFF_CTRL: next_regRdData[CTRL_INFEED_BIT] = infeedObject;
                OFF_STATUS: next_regRdData = {8'h00, attemptCnt, 3'h0, state,
                                              4'h0, attemptsExceededFault, ackIssued,
                                              powerUpReq, restartActive};
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            restartModeSelect <= RST_MODE;
            startAttemptCount <= RST_ATTEMPTS;
            attemptDelayTime <= RST_DELAY_MS;
            supplyReturnMonitorTime <= RST_MONITOR_MS;
            infeedObject <= 1'b0;
            regRdData <= '0;
        end else begin
            restartModeSelect <= next_restartModeSelect;
            startAttemptCount <= next_startAttemptCount;
            attemptDelayTime <= next_attemptDelayTime;
            supplyReturnMonitorTime <= next_supplyReturnMonitorTime;
            infeedObject <= next_infeedObject;
            regRdData <= next_regRdData;
        end
    end

    // qualifying events per mode; unlisted mode codes qualify nothing, as off does
    always_comb begin
        modeRestart = (restartModeSelect == MODE_LINE) || (restartModeSelect == MODE_ANY);
        lineEvt = modLine || trig1 || (infeedObject && infLine) // [RULE8]
                  || auxLost; // [RULE10]
        unique case (restartModeSelect)
            MODE_ACK: qualify = fault; // [RULE3] [RULE4]
            MODE_LINE: qualify = lineEvt; // [RULE8]
            MODE_ANY: qualify = fault || trig0; // [RULE11]
            default: qualify = 1'b0; // [RULE1]
        endcase
        // zero delay would hammer the fault source, so keep at least one tick
        halfDelay = (attemptDelayTime >> 1) == '0 ? TIME_W'(1) : attemptDelayTime >> 1; // [RULE17]
        succAck = ackIssued && !fault;
        monExpire = modeRestart && (supplyReturnMonitorTime != '0) // [RULE19]
                    && (monitorMs >= supplyReturnMonitorTime); // [RULE13]
        successEvt = (state == ST_START) && magDone && tick
                     && (phaseMs + TIME_W'(1) >= SUCCESS_HOLD_MS); // [RULE18]
    end

    // restart sequencer
    always_comb begin
        next_state = state;
        next_attemptCnt = attemptCnt;
        next_phaseMs = phaseMs;
        next_monitorMs = monitorMs;
        next_ackIssued = ackIssued;
        next_faultAck = 1'b0;
        excSet = 1'b0;
        if (tick && state != ST_IDLE && state != ST_LOCK) begin
            next_monitorMs = monitorMs + TIME_W'(1);
        end
        unique case (state)
            ST_IDLE: begin
                if (qualify) begin
                    next_state = ST_ACK;
                    next_phaseMs = '0;
                    next_monitorMs = '0; // [RULE13]
                    next_ackIssued = 1'b0;
                end
            end
            ST_ACK: begin
                if (tick) begin
                    next_phaseMs = phaseMs + TIME_W'(1);
                end
                if (fault && tick && phaseMs + TIME_W'(1) >= halfDelay) begin
                    next_faultAck = 1'b1; // [RULE2] [RULE9] [RULE17]
                    next_phaseMs = '0;
                    next_ackIssued = 1'b1;
                end
                if (succAck) begin
                    next_ackIssued = 1'b0;
                    if (modeRestart) begin
                        if (attemptCnt == '0) begin
                            excSet = 1'b1; // [RULE16]
                        end else begin
                            next_attemptCnt = attemptCnt - CNT_W'(1); // [RULE17] [RULE12]
                        end
                    end
                end
                if (restartModeSelect == MODE_ACK) begin
                    if (!fault) begin
                        next_state = ST_IDLE; // [RULE3] [RULE7]
                    end
                end else if (!modeRestart) begin
                    next_state = ST_IDLE; // [RULE1]
                end else if (excSet || monExpire) begin
                    excSet = 1'b1; // [RULE19]
                    next_state = ST_LOCK;
                end else if (!fault) begin
                    next_state = ST_WAIT; // [RULE9]
                end
            end
            ST_WAIT: begin
                if (!modeRestart) begin
                    next_state = ST_IDLE;
                end else if (fault) begin
                    next_state = ST_ACK;
                    next_phaseMs = '0;
                end else if (monExpire) begin
                    excSet = 1'b1; // [RULE19]
                    next_state = ST_LOCK;
                end else if (ready) begin
                    next_state = ST_START; // [RULE2] [RULE14]
                    next_phaseMs = '0;
                end
            end
            ST_START: begin
                if (magDone && tick) begin
                    next_phaseMs = phaseMs + TIME_W'(1);
                end
                if (!modeRestart) begin
                    next_state = ST_IDLE;
                end else if (fault) begin
                    next_state = ST_ACK;
                    next_phaseMs = '0;
                end else if (successEvt) begin
                    next_attemptCnt = startAttemptCount; // [RULE18] [RULE12]
                    next_state = ST_IDLE;
                end else if (monExpire && !magDone) begin
                    excSet = 1'b1; // [RULE19]
                    next_state = ST_LOCK;
                end
            end
            ST_LOCK: begin
                if (clrExc || restartModeSelect == MODE_OFF) begin
                    next_state = ST_IDLE;
                    next_attemptCnt = startAttemptCount;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        // the new trip wins over a clear in the same cycle
        next_exc = excSet || (attemptsExceededFault && !clrExc);
        // power-up only in a restart mode, only from the start phase
        next_powerUpReq = (next_state == ST_START) && runCmd && modeRestart; // [RULE14]
        next_restartActive = (next_state != ST_IDLE);
    end

    // counter and timers clear on reset; the counter is loaded on first use
    logic cntLoaded;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= ST_IDLE; // [RULE20]
            attemptCnt <= '0;
            cntLoaded <= 1'b0;
            phaseMs <= '0;
            monitorMs <= '0;
            ackIssued <= 1'b0;
            faultAck <= 1'b0;
            powerUpReq <= 1'b0;
            attemptsExceededFault <= 1'b0;
            restartActive <= 1'b0;
        end else begin
            state <= next_state;
            if (!cntLoaded && state == ST_IDLE && qualify) begin
                attemptCnt <= startAttemptCount; // [RULE12]
                cntLoaded <= 1'b1;
            end else begin
                attemptCnt <= next_attemptCnt;
            end
            phaseMs <= next_phaseMs;
            monitorMs <= next_monitorMs;
            ackIssued <= next_ackIssued;
            faultAck <= next_faultAck;
            powerUpReq <= next_powerUpReq;
            attemptsExceededFault <= next_exc;
            restartActive <= next_restartActive;
        end
    end

    // ticks since the last acknowledge, saturating; the spacing check then follows the tick rate
    logic [TIME_W-1:0] ackGap, next_ackGap;
    always_comb begin
        next_ackGap = ackGap;
        if (faultAck) begin
            next_ackGap = '0;
        end else if (tick && ackGap != '1) begin
            next_ackGap = ackGap + TIME_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ackGap <= '1;
        end else begin
            ackGap <= next_ackGap;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_ack_pulse;
        faultAck ##1 !faultAck;
    endsequence

    a_mode_off_idle: assert property ((restartModeSelect == MODE_OFF) && !regWrite // [RULE1]
        |=> state == ST_IDLE ##1 state == ST_IDLE)
        else $error("sequencer left idle while mode is off");
    a_ack_only_nostart: assert property ((restartModeSelect == MODE_ACK) && $stable(restartModeSelect) // [RULE3]
        |=> !powerUpReq)
        else $error("power-up requested in acknowledge-only mode");
    a_ack_only_noexc: assert property ((restartModeSelect == MODE_ACK) && !attemptsExceededFault // [RULE7]
        && $past(restartModeSelect) == MODE_ACK |=> !attemptsExceededFault)
        else $error("attempts fault raised in acknowledge-only mode");
    a_ack_spacing: assert property (faultAck |-> ackGap >= halfDelay ##0 s_ack_pulse) // [RULE17]
        else $error("acknowledge pulses too close together");
    a_exc_on_zero: assert property (state == ST_ACK && succAck && modeRestart && attemptCnt == '0 // [RULE16]
        |=> attemptsExceededFault && state == ST_LOCK)
        else $error("attempt overrun did not raise the fault");
    a_cnt_decrement: assert property (state == ST_ACK && succAck && modeRestart // [RULE17]
        && attemptCnt != '0 |=> attemptCnt == $past(attemptCnt) - CNT_W'(1))
        else $error("attempt counter did not step down after acknowledge");
    a_monitor_trip: assert property (state == ST_WAIT && monExpire && !fault && modeRestart // [RULE19]
        |=> attemptsExceededFault ##1 state == ST_LOCK || attemptsExceededFault)
        else $error("monitor expiry did not raise the fault");
    a_line_qualify: assert property (state == ST_IDLE && restartModeSelect == MODE_LINE // [RULE8]
        && !lineEvt |=> state == ST_IDLE)
        else $error("line mode left idle without a line event");
    a_success_reload: assert property (successEvt && modeRestart && !fault // [RULE18]
        |=> attemptCnt == $past(startAttemptCount) && state == ST_IDLE)
        else $error("attempt counter not reloaded after a good start");
    a_powerup_state: assert property (powerUpReq |-> state == ST_START && restartModeSelect != MODE_ACK) // [RULE2]
        else $error("power-up request outside the start phase");
endmodule
`default_nettype wire

/* File: tb/arc_far_side.sv */
// far-side model: fault sources and line infeed facing the restart controller
`timescale 1ns/10ps
`default_nettype none
module arc_far_side (
    input wire logic clk,
    input wire logic raise,
    input wire logic [2:0] kind,
    input wire logic keep,
    input wire logic clear,
    input wire logic faultAck,
    input wire logic powerUpReq,
    output logic faultPending,
    output logic moduleLineFailureFault,
    output logic infeedLineFailureFault,
    output logic auxSupplyLost,
    output logic [1:0] restartTriggerInputs,
    output logic infeedReady,
    output logic magnetizationDoneFlag
);
    logic flt = 1'b0;
    logic [2:0] held = 3'h0;
    int magWait = 0;
    // a fault clears on acknowledge unless it is told to persist, as a stuck cause would
    always @(posedge clk) begin
        if (raise) begin
            flt <= 1'b1;
            held <= kind;
        end else if (clear || (faultAck && !keep)) begin
            flt <= 1'b0;
        end
    end
    // kind 0 plain fault, 1 module line, 2 aux supply, 3 trigger1, 4 trigger0, 5 infeed
    assign faultPending = flt;
    assign moduleLineFailureFault = flt && (held == 3'h1);
    assign auxSupplyLost = flt && (held == 3'h2);
    assign infeedLineFailureFault = flt && (held == 3'h5);
    assign restartTriggerInputs = {flt && (held == 3'h3), flt && (held == 3'h4)};
    // supply is back once no line-type fault is present
    assign infeedReady = !(moduleLineFailureFault || auxSupplyLost || infeedLineFailureFault);
    // flying restart assumed enabled: magnetization completes 20 cycles after power-up
    always @(posedge clk) begin
        magWait <= powerUpReq ? magWait + 1 : 0;
    end
    assign magnetizationDoneFlag = powerUpReq && (magWait >= 20);
endmodule
`default_nettype wire

/* File: tb/tb_automatic_restart_controller.sv */
// self-checking testbench of the automatic restart controller
`timescale 1ns/10ps
`default_nettype none
module tb_automatic_restart_controller;
    import arc_pkg::*;
    localparam int TK = 4;
    localparam int ATT = 5;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [ADDR_W-1:0] regAddr = 8'h00;
    logic [DATA_W-1:0] regWrData = 32'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [DATA_W-1:0] regRdData;
    logic runCommand = 1'b0;
    logic raise = 1'b0;
    logic [2:0] kind = 3'h0;
    logic keep = 1'b0;
    logic clear = 1'b0;
    logic faultPending, moduleLineFailureFault, infeedLineFailureFault, auxSupplyLost;
    logic [1:0] restartTriggerInputs;
    logic infeedReady, magnetizationDoneFlag;
    logic faultAck, powerUpReq, attemptsExceededFault, restartActive;
    int errCount = 0;
    int nCompared = 0;
    always #4 clk = ~clk;
    arc_restart_ctrl #(.TICK_CYCLES(TK)) dut_u (.clk(clk), .nrst(nrst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .faultPending(faultPending), .moduleLineFailureFault(moduleLineFailureFault),
        .infeedLineFailureFault(infeedLineFailureFault), .auxSupplyLost(auxSupplyLost),
        .restartTriggerInputs(restartTriggerInputs), .runCommand(runCommand),
        .infeedReady(infeedReady), .magnetizationDoneFlag(magnetizationDoneFlag),
        .faultAck(faultAck), .powerUpReq(powerUpReq),
        .attemptsExceededFault(attemptsExceededFault), .restartActive(restartActive));
    arc_far_side far_u (.clk(clk), .raise(raise), .kind(kind), .keep(keep), .clear(clear),
        .faultAck(faultAck), .powerUpReq(powerUpReq), .faultPending(faultPending),
        .moduleLineFailureFault(moduleLineFailureFault),
        .infeedLineFailureFault(infeedLineFailureFault), .auxSupplyLost(auxSupplyLost),
        .restartTriggerInputs(restartTriggerInputs), .infeedReady(infeedReady),
        .magnetizationDoneFlag(magnetizationDoneFlag));
    task automatic closeOut();
        $display("compared %0d, mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        nCompared++;
        if (got !== exp) begin
            errCount++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // one-cycle strobes launched just after an edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] exp,
        input string what);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 check(regRdData & msk, exp, what);
    endtask
    function automatic logic pick(input int w);
        case (w)
            0: return faultAck;
            1: return powerUpReq;
            2: return attemptsExceededFault;
            3: return restartActive;
            default: return !restartActive;
        endcase
    endfunction
    // bounded watch: want=1 means the output must show up, want=0 that it must stay low
    task automatic watch(input int w, input int lim, input logic want, input string what);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < lim && !(seen && want); i++) begin
            @(posedge clk);
            #1;
            if (pick(w) === 1'b1) seen = 1'b1;
        end
        check({31'h0, seen}, {31'h0, want}, what);
    endtask
    task automatic fault(input logic [2:0] k, input logic kp);
        @(posedge clk);
        raise <= 1'b1;
        kind <= k;
        keep <= kp;
        @(posedge clk);
        raise <= 1'b0;
    endtask
    task automatic clr();
        @(posedge clk);
        clear <= 1'b1;
        @(posedge clk);
        clear <= 1'b0;
    endtask
    task automatic t_reset();
        rdc(OFF_MODE, 32'hffffffff, 32'h0, "mode after reset");
        rdc(OFF_ATTEMPTS, 32'hffffffff, 32'h3, "attempts after reset");
        rdc(OFF_DELAY, 32'hffffffff, 32'h3e8, "delay after reset");
        rdc(OFF_MONITOR, 32'hffffffff, 32'hea60, "monitor after reset");
        rdc(8'h20, 32'hffffffff, 32'h0, "unmapped read");
        rdc(OFF_STATUS, 32'hffffffff, 32'h100, "status after reset");
    endtask
    // a fault that the selected mode does not qualify must leave the sequencer idle
    task automatic t_quiet(input logic [2:0] m, input logic [2:0] k);
        wr(OFF_MODE, {29'h0, m});
        fault(k, 1'b0);
        watch(3, 200, 1'b0, "sequencer stays idle");
        clr();
    endtask
    task automatic t_ack_only();
        wr(OFF_MONITOR, 32'h1e);
        wr(OFF_MODE, {29'h0, MODE_ACK});
        runCommand <= 1'b0;
        repeat (2) begin
            fault(3'h0, 1'b0);
            watch(0, 100, 1'b1, "ack-only acknowledge");
            watch(1, 60, 1'b0, "ack-only never powers up");
            repeat (1000 * TK + 100) @(posedge clk);
            runCommand <= 1'b1;
        end
        // a stuck fault makes every attempt fail, past the monitor time
        fault(3'h0, 1'b1);
        watch(2, 400, 1'b0, "ack-only never exceeded");
        clr();
        repeat (40) @(posedge clk);
    endtask
    task automatic t_restart(input logic [2:0] m, input logic [2:0] k);
        wr(OFF_MODE, {29'h0, m});
        runCommand <= 1'b1;
        fault(k, 1'b0);
        watch(0, 100, 1'b1, "restart acknowledge");
        watch(1, 100, 1'b1, "power-up issued");
        rdc(OFF_STATUS, 32'h00ff0000, ATT - 1 << 16, "count after ack");
        repeat (900 * TK) @(posedge clk);
        #1 check({31'h0, powerUpReq}, 32'h1, "held before success");
        watch(4, 150 * TK, 1'b1, "idle after success");
        rdc(OFF_STATUS, 32'h00ff1f00, ATT << 16 | 32'h100, "count reloaded");
    endtask
    task automatic t_monitor();
        wr(OFF_MONITOR, 32'h1e);
        wr(OFF_MODE, {29'h0, MODE_ANY});
        fault(3'h0, 1'b1);
        watch(2, 20 * TK, 1'b0, "no early expiry");
        watch(2, 20 * TK + 60, 1'b1, "monitor expiry");
        clr();
        wr(OFF_ATTEMPTS, 32'h0);
        wr(OFF_CTRL, 32'h2);
        watch(2, 20, 1'b0, "exceeded cleared");
        wr(OFF_MONITOR, 32'h0);
        fault(3'h0, 1'b1);
        watch(2, 300, 1'b0, "monitor disabled");
        clr();
        watch(2, 40, 1'b1, "count exhausted");
        wr(OFF_MODE, 32'h0);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        wr(OFF_DELAY, 32'h4);
        wr(OFF_ATTEMPTS, ATT);
        t_quiet(MODE_OFF, 3'h0);
        t_quiet(3'h2, 3'h1);
        t_ack_only();
        wr(OFF_MONITOR, 32'h1f4);
        wr(OFF_CTRL, 32'h1);
        t_quiet(MODE_LINE, 3'h0);
        t_restart(MODE_ANY, 3'h0);
        t_restart(MODE_ANY, 3'h4);
        for (int k = 1; k < 6; k++) begin
            if (k != 4) t_restart(MODE_LINE, k[2:0]);
        end
        t_monitor();
        closeOut();
    end
    // hang guard, well above the roughly 34000 cycles the tests need
    initial begin
        repeat (70000) @(posedge clk);
        errCount++;
        $display("mismatch at %0t: run timed out", $time);
        closeOut();
    end
endmodule
`default_nettype wire
